// *** core/hep_pkg.sv ***
// shared constants for the hub embedded-port command link
`default_nettype none
package hep_pkg;
   // command codes
   localparam logic [7:0] CMD_SCB = 8'hf7;
   localparam logic [7:0] CMD_RESUME = 8'hf6;
   localparam logic [7:0] CMD_FRAME = 8'hf5;
   localparam logic [7:0] CMD_ADDR_EN = 8'hd0;
   localparam logic [7:0] CMD_EP_EN = 8'hd8;
   // status change data byte layout
   localparam int SCB_LPC_BIT = 0;
   localparam int SCB_EMB_BIT = 1;
   // address/enable data byte layout
   localparam int AE_EN_BIT = 7;
   // link phase kinds
   localparam logic [1:0] LK_IDLE = 2'h0;
   localparam logic [1:0] LK_CMD = 2'h1;
   localparam logic [1:0] LK_WR = 2'h2;
   localparam logic [1:0] LK_RD = 2'h3;
   // port feature codes
   localparam logic [2:0] FEAT_ENABLE = 3'h0;
   localparam logic [2:0] FEAT_SUSPEND = 3'h1;
   localparam logic [2:0] FEAT_RESET = 3'h2;
   localparam logic [2:0] FEAT_POWER = 3'h3;
   localparam logic [2:0] FEAT_C_CONN = 3'h4;
   // embedded port change bits
   localparam int CHG_CONN = 0;
   localparam int CHG_ENABLE = 1;
   localparam int CHG_SUSPEND = 2;
   localparam int CHG_OVERCUR = 3;
   localparam int CHG_RESET = 4;
   // embedded port status bits
   localparam int PST_ENABLE = 0;
   localparam int PST_SUSPEND = 1;
   // controller register map (write side)
   localparam logic [2:0] REG_HOSTREQ = 3'h0;
   localparam logic [2:0] REG_EVENT = 3'h1;
   localparam logic [2:0] REG_CONFIG = 3'h2;
   localparam logic [2:0] REG_FNADDR = 3'h3;
   // controller register map (read side)
   localparam logic [2:0] REG_PSTAT = 3'h0;
   localparam logic [2:0] REG_PCHG = 3'h1;
   localparam logic [2:0] REG_FRM_LO = 3'h4;
   localparam logic [2:0] REG_FRM_HI = 3'h5;
   // field positions
   localparam int HREQ_SET_BIT = 7;
   localparam int EV_BABBLE = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_FRAME = 2;
   localparam int CFG_LPC = 0;
   localparam int CFG_HUB_SUSP = 1;
   localparam int CFG_BUSY = 7;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int RESUME_MS = 10;
   localparam int RESUME_CYC = (CLK_HZ / 1000) * RESUME_MS;
   localparam logic [3:0] LK_HALF_CYC = 4'h8;
endpackage : hep_pkg
`default_nettype wire

// *** core/hep_link_if.sv ***
// command link between hub device and its controller
`default_nettype none
interface hep_link_if;
   logic lk_clk;
   logic [1:0] lk_kind;
   logic [7:0] lk_wdata;
   logic [7:0] lk_rdata;
   modport ctl (output lk_clk, output lk_kind, output lk_wdata, input lk_rdata);
   modport dev (input lk_clk, input lk_kind, input lk_wdata, output lk_rdata);
endinterface : hep_link_if
`default_nettype wire

// *** core/hep_dev.sv ***
// hub device end: command decode, resume timer, frame readback
`default_nettype none
module hep_dev #(
   parameter int unsigned RESUME_CYCLES = hep_pkg::RESUME_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // command link
   hep_link_if.dev lk,
   // hub core side
   input wire logic sof_valid,
   input wire logic [10:0] sof_frame,
   input wire logic dn_wake,
   input wire logic emb_babble,
   output logic up_resume,
   output logic [1:0] hub_chg,
   output logic emb_enabled,
   output logic [6:0] emb_addr,
   output logic emb_int_ep_en
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [2:0] ck_s;
   logic [1:0] kd_s1, kd_s2;
   logic [7:0] wd_s1, wd_s2;
   logic rise;
   logic [7:0] cmd_r;
   logic [1:0] dph_r;
   logic [10:0] frame_r;
   logic [10:0] snap_r;
   logic [7:0] rdata_r;
   logic [31:0] res_cnt_r;
   logic res_start;

   // two flops on every link input; the third clock flop only finds the edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ck_s <= 3'h0;
         kd_s1 <= 2'h0;
         kd_s2 <= 2'h0;
         wd_s1 <= 8'h00;
         wd_s2 <= 8'h00;
      end else begin
         ck_s <= {ck_s[1:0], lk.lk_clk};
         kd_s1 <= lk.lk_kind;
         kd_s2 <= kd_s1;
         wd_s1 <= lk.lk_wdata;
         wd_s2 <= wd_s1;
      end
   end
   assign rise = ck_s[1] & ~ck_s[2];

   ////////////////////////////////////////////////////////////////////////////////
   // command byte and data phase count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_r <= 8'h00;
         dph_r <= 2'h0;
      end else if (rise && kd_s2 == hep_pkg::LK_CMD) begin
         cmd_r <= wd_s2;
         dph_r <= 2'h0;
      end else if (rise && kd_s2 != hep_pkg::LK_IDLE && dph_r != 2'h3) begin
         dph_r <= dph_r + 2'h1;
      end
   end

   // status change load: only the first data byte counts, extras are ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hub_chg <= 2'h0;
      end else if (rise && kd_s2 == hep_pkg::LK_WR && cmd_r == hep_pkg::CMD_SCB
                   && dph_r == 2'h0) begin
         hub_chg <= {wd_s2[hep_pkg::SCB_EMB_BIT], wd_s2[hep_pkg::SCB_LPC_BIT]};
      end
   end

   // embedded function enable/address; babble disables it on its own
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         emb_enabled <= 1'b0;
         emb_addr <= 7'h00;
         emb_int_ep_en <= 1'b0;
      end else begin
         if (rise && kd_s2 == hep_pkg::LK_WR && dph_r == 2'h0) begin
            if (cmd_r == hep_pkg::CMD_ADDR_EN) begin
               emb_enabled <= wd_s2[hep_pkg::AE_EN_BIT];
               emb_addr <= wd_s2[6:0];
            end
            if (cmd_r == hep_pkg::CMD_EP_EN) begin
               emb_int_ep_en <= wd_s2[0];
            end
         end
         if (emb_babble) begin
            emb_enabled <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // frame of the last good start-of-frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_r <= 11'h000;
      end else if (sof_valid) begin
         frame_r <= sof_frame;
      end
   end

   // snapshot at the command so both bytes belong to one frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_r <= 11'h000;
         rdata_r <= 8'h00;
      end else if (rise && kd_s2 == hep_pkg::LK_CMD && wd_s2 == hep_pkg::CMD_FRAME) begin
         snap_r <= frame_r;
         rdata_r <= frame_r[7:0];
      end else if (rise && kd_s2 == hep_pkg::LK_RD && cmd_r == hep_pkg::CMD_FRAME
                   && dph_r == 2'h0) begin
         rdata_r <= {5'h00, snap_r[10:8]};
      end
   end
   assign lk.lk_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // resume has no data phase; a downstream wake starts it without a command
   assign res_start = (rise && kd_s2 == hep_pkg::LK_CMD && wd_s2 == hep_pkg::CMD_RESUME)
                      || dn_wake;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_cnt_r <= 32'h0;
         up_resume <= 1'b0;
      end else if (res_start) begin
         res_cnt_r <= RESUME_CYCLES[31:0];
         up_resume <= 1'b1;
      end else if (res_cnt_r != 32'h0) begin
         res_cnt_r <= res_cnt_r - 32'h1;
         up_resume <= (res_cnt_r != 32'h1);
      end
   end
endmodule : hep_dev
`default_nettype wire

// *** core/hep_ctl.sv ***
// controller end: embedded port emulation and command sequencing
// Functional notes
// - status change load F7h, exactly one byte
// - local power bit0, embedded bit1, rest zero
// - device keeps both flags as two hub change bits
// - F6h drives upstream resume for 10 ms
// - resume command carries no data phase
// - downstream wake starts resume without command
// - F5h returns last good frame number
// - frame low byte first, high second
// - controller keeps port bits, derives change flag
// - port reset: reinit, reset change, address 0
// - set enable: enable function, set status
// - clear enable: disable function, clear status
// - set suspend: disable, clear enable, suspend
// - clear suspend: enable, resume change set
// - clear change request clears only that bit
// - device disables babbling function by itself
// - babble: set enable change, clear enable
// - wake, hub active: re-enable, update flags
// - wake, both suspended: resume first, re-enable
// - wake, port enabled: resume command only
// - feature byte codes 0 to 7
`default_nettype none
module hep_ctl (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // software register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // command link
   hep_link_if.ctl lk
);
   typedef enum {HEP_L_IDLE, HEP_L_LOW, HEP_L_HIGH} hep_lstate_t;
   typedef enum {HEP_OP_RES, HEP_OP_AE, HEP_OP_EP, HEP_OP_SCB, HEP_OP_FRM} hep_op_t;

   ////////////////////////////////////////////////////////////////////////////////
   // byte idx of an operation; index 0 is always the command
   function automatic logic [7:0] op_byte(input hep_op_t op, input logic [1:0] idx,
                                          input logic [7:0] ae, input logic [7:0] scb);
      logic [7:0] b;
      b = 8'h00;
      case (op)
         HEP_OP_RES: b = hep_pkg::CMD_RESUME;
         HEP_OP_AE: b = (idx == 2'h0) ? hep_pkg::CMD_ADDR_EN : ae;
         HEP_OP_EP: b = (idx == 2'h0) ? hep_pkg::CMD_EP_EN : 8'h00;
         HEP_OP_SCB: b = (idx == 2'h0) ? hep_pkg::CMD_SCB : scb;
         HEP_OP_FRM: b = (idx == 2'h0) ? hep_pkg::CMD_FRAME : 8'h00;
         default: b = 8'h00;
      endcase
      return b;
   endfunction : op_byte

   // number of link bytes an operation takes
   function automatic logic [1:0] op_len(input hep_op_t op);
      logic [1:0] n;
      n = 2'h2;
      case (op)
         HEP_OP_RES: n = 2'h1;
         HEP_OP_FRM: n = 2'h3;
         default: n = 2'h2;
      endcase
      return n;
   endfunction : op_len

   ////////////////////////////////////////////////////////////////////////////////
   logic pst_en_r, pst_susp_r;
   logic [4:0] chg_r;
   logic lpc_r, hub_susp_r;
   logic [6:0] fn_addr_r;
   logic ae_en_r;
   logic [6:0] ae_addr_r;
   logic p_res_r, p_ae_r, p_ep_r, p_scb_r, p_frm_r;
   hep_lstate_t ls_r;
   hep_op_t op_r;
   logic [1:0] idx_r;
   logic [3:0] hc_r;
   logic [7:0] frm_lo_r;
   logic [2:0] frm_hi_r;
   logic [7:0] rd_s1, rd_s2;
   logic clk_o_r;
   logic [1:0] kind_r;
   logic [7:0] wdata_r;
   logic start;
   hep_op_t pick;
   logic [7:0] scb_byte;
   logic hreq_wr, ev_wr;
   logic hset;
   logic [2:0] feat;
   logic half_done;
   logic last;

   assign hreq_wr = reg_wr && reg_addr == hep_pkg::REG_HOSTREQ;
   assign ev_wr = reg_wr && reg_addr == hep_pkg::REG_EVENT;
   assign hset = reg_wdata[hep_pkg::HREQ_SET_BIT];
   assign feat = reg_wdata[2:0];
   // embedded flag derived from the kept change bits
   assign scb_byte = {6'h00, |chg_r, lpc_r};

   ////////////////////////////////////////////////////////////////////////////////
   // embedded port status bits as the host sees them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pst_en_r <= 1'b0;
         pst_susp_r <= 1'b0;
      end else if (hreq_wr && hset) begin
         if (feat == hep_pkg::FEAT_RESET || feat == hep_pkg::FEAT_SUSPEND) begin
            pst_en_r <= 1'b0;
         end else if (feat == hep_pkg::FEAT_ENABLE) begin
            pst_en_r <= 1'b1;
         end
         if (feat == hep_pkg::FEAT_SUSPEND) begin
            pst_susp_r <= 1'b1;
         end
      end else if (hreq_wr) begin
         if (feat == hep_pkg::FEAT_ENABLE) begin
            pst_en_r <= 1'b0;
         end else if (feat == hep_pkg::FEAT_SUSPEND) begin
            pst_en_r <= 1'b1;
            pst_susp_r <= 1'b0;
         end
      end else if (ev_wr && reg_wdata[hep_pkg::EV_BABBLE]) begin
         pst_en_r <= 1'b0;
      end else if (ev_wr && reg_wdata[hep_pkg::EV_WAKE] && pst_susp_r) begin
         pst_en_r <= 1'b1;
         pst_susp_r <= 1'b0;
      end
   end

   // change bits; a clear request touches only the matching bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chg_r <= 5'h00;
      end else if (hreq_wr && hset) begin
         if (feat == hep_pkg::FEAT_RESET) begin
            chg_r[hep_pkg::CHG_RESET] <= 1'b1;
         end
      end else if (hreq_wr) begin
         if (feat == hep_pkg::FEAT_SUSPEND) begin
            chg_r[hep_pkg::CHG_SUSPEND] <= 1'b1;
         end else if (feat == hep_pkg::FEAT_RESET) begin
            chg_r[hep_pkg::CHG_RESET] <= 1'b0;
         end else if (feat >= hep_pkg::FEAT_C_CONN) begin
            chg_r[feat[1:0]] <= 1'b0;
         end
      end else if (ev_wr && reg_wdata[hep_pkg::EV_BABBLE]) begin
         chg_r[hep_pkg::CHG_ENABLE] <= 1'b1;
      end else if (ev_wr && reg_wdata[hep_pkg::EV_WAKE] && pst_susp_r) begin
         chg_r[hep_pkg::CHG_SUSPEND] <= 1'b1;
      end
   end

   // value for the next address/enable command
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ae_en_r <= 1'b0;
         ae_addr_r <= 7'h00;
      end else if (hreq_wr && hset && feat == hep_pkg::FEAT_RESET) begin
         ae_en_r <= 1'b1;
         ae_addr_r <= 7'h00;
      end else if (hreq_wr && feat == hep_pkg::FEAT_ENABLE) begin
         ae_en_r <= hset;
         ae_addr_r <= fn_addr_r;
      end else if (hreq_wr && feat == hep_pkg::FEAT_SUSPEND) begin
         ae_en_r <= ~hset;
         ae_addr_r <= fn_addr_r;
      end else if (ev_wr && reg_wdata[hep_pkg::EV_WAKE] && pst_susp_r) begin
         ae_en_r <= 1'b1;
         ae_addr_r <= fn_addr_r;
      end
   end

   // software configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lpc_r <= 1'b0;
         hub_susp_r <= 1'b0;
         fn_addr_r <= 7'h00;
      end else if (reg_wr && reg_addr == hep_pkg::REG_CONFIG) begin
         lpc_r <= reg_wdata[hep_pkg::CFG_LPC];
         hub_susp_r <= reg_wdata[hep_pkg::CFG_HUB_SUSP];
      end else if (reg_wr && reg_addr == hep_pkg::REG_FNADDR) begin
         fn_addr_r <= reg_wdata[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pending operations; a new request wins over the start that clears it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         p_res_r <= 1'b0;
         p_ae_r <= 1'b0;
         p_ep_r <= 1'b0;
         p_scb_r <= 1'b0;
         p_frm_r <= 1'b0;
      end else begin
         if (start) begin
            p_res_r <= p_res_r && pick != HEP_OP_RES;
            p_ae_r <= p_ae_r && pick != HEP_OP_AE;
            p_ep_r <= p_ep_r && pick != HEP_OP_EP;
            p_scb_r <= p_scb_r && pick != HEP_OP_SCB;
            p_frm_r <= p_frm_r && pick != HEP_OP_FRM;
         end
         if (hreq_wr && feat <= hep_pkg::FEAT_SUSPEND) begin
            p_ae_r <= 1'b1;
         end
         if (hreq_wr && hset && feat == hep_pkg::FEAT_RESET) begin
            p_ae_r <= 1'b1;
            p_ep_r <= 1'b1;
         end
         if (hreq_wr || ev_wr || (reg_wr && reg_addr == hep_pkg::REG_CONFIG)) begin
            p_scb_r <= 1'b1;
         end
         if (ev_wr && reg_wdata[hep_pkg::EV_WAKE]) begin
            if (hub_susp_r) begin
               p_res_r <= 1'b1;
            end
            if (pst_susp_r) begin
               p_ae_r <= 1'b1;
            end
         end
         if (ev_wr && reg_wdata[hep_pkg::EV_FRAME]) begin
            p_frm_r <= 1'b1;
         end
      end
   end

   // resume goes out ahead of the re-enable
   always_comb begin
      pick = HEP_OP_FRM;
      if (p_res_r) begin
         pick = HEP_OP_RES;
      end else if (p_ae_r) begin
         pick = HEP_OP_AE;
      end else if (p_ep_r) begin
         pick = HEP_OP_EP;
      end else if (p_scb_r) begin
         pick = HEP_OP_SCB;
      end
   end
   assign start = ls_r == HEP_L_IDLE &&
                  (p_res_r || p_ae_r || p_ep_r || p_scb_r || p_frm_r);
   assign half_done = hc_r == hep_pkg::LK_HALF_CYC - 4'h1;
   assign last = idx_r == op_len(op_r) - 2'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // link engine: one byte per divided link clock, data set while clock is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ls_r <= HEP_L_IDLE;
         op_r <= HEP_OP_RES;
         idx_r <= 2'h0;
         hc_r <= 4'h0;
         clk_o_r <= 1'b0;
         kind_r <= hep_pkg::LK_IDLE;
         wdata_r <= 8'h00;
      end else begin
         case (ls_r)
            HEP_L_IDLE: begin
               if (start) begin
                  op_r <= pick;
                  idx_r <= 2'h0;
                  hc_r <= 4'h0;
                  kind_r <= hep_pkg::LK_CMD;
                  wdata_r <= op_byte(pick, 2'h0, {ae_en_r, ae_addr_r}, scb_byte);
                  ls_r <= HEP_L_LOW;
               end
            end
            HEP_L_LOW: begin
               hc_r <= half_done ? 4'h0 : hc_r + 4'h1;
               if (half_done) begin
                  clk_o_r <= 1'b1;
                  ls_r <= HEP_L_HIGH;
               end
            end
            HEP_L_HIGH: begin
               hc_r <= half_done ? 4'h0 : hc_r + 4'h1;
               if (half_done) begin
                  clk_o_r <= 1'b0;
                  if (last) begin
                     kind_r <= hep_pkg::LK_IDLE;
                     ls_r <= HEP_L_IDLE;
                  end else begin
                     idx_r <= idx_r + 2'h1;
                     kind_r <= (op_r == HEP_OP_FRM) ? hep_pkg::LK_RD : hep_pkg::LK_WR;
                     wdata_r <= op_byte(op_r, idx_r + 2'h1, {ae_en_r, ae_addr_r}, scb_byte);
                     ls_r <= HEP_L_LOW;
                  end
               end
            end
            default: ls_r <= HEP_L_IDLE;
         endcase
      end
   end
   assign lk.lk_clk = clk_o_r;
   assign lk.lk_kind = kind_r;
   assign lk.lk_wdata = wdata_r;

   // read data from the device crosses in through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_s1 <= 8'h00;
         rd_s2 <= 8'h00;
      end else begin
         rd_s1 <= lk.lk_rdata;
         rd_s2 <= rd_s1;
      end
   end

   // frame bytes sampled as the clock rises; low byte comes first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frm_lo_r <= 8'h00;
         frm_hi_r <= 3'h0;
      end else if (ls_r == HEP_L_LOW && half_done && kind_r == hep_pkg::LK_RD) begin
         if (idx_r == 2'h1) begin
            frm_lo_r <= rd_s2;
         end else begin
            frm_hi_r <= rd_s2[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register read port, data one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == hep_pkg::REG_PSTAT) begin
            reg_rdata <= {6'h00, pst_susp_r, pst_en_r};
         end else if (reg_addr == hep_pkg::REG_PCHG) begin
            reg_rdata <= {3'h0, chg_r};
         end else if (reg_addr == hep_pkg::REG_CONFIG) begin
            reg_rdata <= {~start && ls_r != HEP_L_IDLE || start, 5'h00, hub_susp_r, lpc_r};
         end else if (reg_addr == hep_pkg::REG_FNADDR) begin
            reg_rdata <= {1'b0, fn_addr_r};
         end else if (reg_addr == hep_pkg::REG_FRM_LO) begin
            reg_rdata <= frm_lo_r;
         end else if (reg_addr == hep_pkg::REG_FRM_HI) begin
            reg_rdata <= {5'h00, frm_hi_r};
         end else begin
            reg_rdata <= 8'h00;
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : hep_ctl
`default_nettype wire

// *** sim/hep_link_monitor.sv ***
// link monitor: protocol assertions on the hub command link wires
`default_nettype none
module hep_link_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link wires
   input wire logic lk_clk,
   input wire logic [1:0] lk_kind,
   input wire logic [7:0] lk_wdata,
   input wire logic [7:0] lk_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic clk_q;
   logic rd2_r;
   logic [7:0] cmd_r;
   wire logic rise = lk_clk & ~clk_q;
   ////////////////////////////////////////////////////////////
   // last command and read index, so a data phase knows what it belongs to
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_q <= 1'b0;
         rd2_r <= 1'b0;
         cmd_r <= 8'h00;
      end else begin
         clk_q <= lk_clk;
         if (rise && lk_kind == hep_pkg::LK_CMD) begin
            cmd_r <= lk_wdata;
            rd2_r <= 1'b0;
         end else if (rise && lk_kind == hep_pkg::LK_RD) begin
            rd2_r <= 1'b1;
         end
      end
   end
   sequence s_cmd(logic [7:0] c);
      rise && lk_kind == hep_pkg::LK_CMD && lk_wdata == c;
   endsequence
   ////////////////////////////////////////////////////////////
   // framing: the device samples at the rise, so the phase must hold while high
   a_kind_hold: assert property (lk_clk && $past(lk_clk) |-> $stable(lk_kind) && $stable(lk_wdata))
      else $error("link phase changed while link clock high");
   a_clk_high: assert property (rise |-> lk_clk[*8] ##1 !lk_clk)
      else $error("link clock high time not 8 cycles");
   a_clk_low: assert property ($fell(lk_clk) && lk_kind != hep_pkg::LK_IDLE |-> !lk_clk[*8])
      else $error("link clock low time within a transfer not 8 cycles");
   // kind bit 1 set means a write or read data phase
   a_resume_nodata: assert property (s_cmd(hep_pkg::CMD_RESUME) |-> ##8 !lk_kind[1])
      else $error("data phase after resume command");
   a_scb_one_byte: assert property (s_cmd(hep_pkg::CMD_SCB) |->
      ##8 lk_kind == hep_pkg::LK_WR ##16 lk_kind != hep_pkg::LK_WR)
      else $error("status change load not followed by exactly one write");
   a_scb_pad_zero: assert property (rise && lk_kind == hep_pkg::LK_WR &&
      cmd_r == hep_pkg::CMD_SCB |-> lk_wdata[7:2] == 6'h00)
      else $error("status change byte has upper bits set");
   a_frame_two_reads: assert property (s_cmd(hep_pkg::CMD_FRAME) |->
      ##8 lk_kind == hep_pkg::LK_RD ##16 lk_kind == hep_pkg::LK_RD)
      else $error("frame command not followed by two reads");
   a_frame_hi_last: assert property (rise && lk_kind == hep_pkg::LK_RD && rd2_r |->
      lk_rdata[7:3] == 5'h00)
      else $error("second frame byte is not the high byte");
   c_scb: cover property (s_cmd(hep_pkg::CMD_SCB));
   c_resume: cover property (s_cmd(hep_pkg::CMD_RESUME));
   c_frame: cover property (s_cmd(hep_pkg::CMD_FRAME));
endmodule : hep_link_monitor
`default_nettype wire

// *** sim/hep_tb.sv ***
// testbench: controller and device joined over the command link
`default_nettype none
module hep_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RES = 50;
   logic clk;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic sof_valid = 1'b0;
   logic dn_wake = 1'b0;
   logic emb_babble = 1'b0;
   logic [10:0] sof_frame = 11'h000;
   logic up_resume;
   logic emb_enabled;
   logic emb_int_ep_en;
   logic [1:0] hub_chg;
   logic [6:0] emb_addr;
   logic [7:0] res_n = 8'h00;
   logic [7:0] res_len = 8'h00;
   logic [7:0] res_cyc = 8'h00;
   logic [7:0] rdv;
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   hep_link_if lk_if ();
   hep_dev #(.RESUME_CYCLES(RES)) hep_dev_i (.clk(clk), .rst_n(rst_n), .lk(lk_if),
      .sof_valid(sof_valid), .sof_frame(sof_frame), .dn_wake(dn_wake),
      .emb_babble(emb_babble), .up_resume(up_resume), .hub_chg(hub_chg),
      .emb_enabled(emb_enabled), .emb_addr(emb_addr), .emb_int_ep_en(emb_int_ep_en));
   hep_ctl hep_ctl_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lk(lk_if));
   hep_link_monitor hep_link_monitor_i (.clk(clk), .rst_n(rst_n), .lk_clk(lk_if.lk_clk),
      .lk_kind(lk_if.lk_kind), .lk_wdata(lk_if.lk_wdata), .lk_rdata(lk_if.lk_rdata));
   // 20 MHz system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   // access tasks and comparisons
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // write, then poll busy so every queued link transfer has finished
   task automatic req(input logic [2:0] a, input logic [7:0] d);
      wr(a, d);
      rdv = 8'h80;
      for (int i = 0; i < 300 && rdv[7] !== 1'b0; i++) rd(3'h2, rdv);
      chk("busy", 16'h0000, {8'h00, rdv[7], 7'h00});
   endtask : req
   // port status, port change bits and device side outputs in one go
   task automatic st(input logic [1:0] ps, input logic [4:0] pc, input logic [9:0] dv);
      rd(3'h0, rdv);
      chk("pstat", {14'h0000, ps}, {8'h00, rdv});
      rd(3'h1, rdv);
      chk("pchg", {11'h000, pc}, {8'h00, rdv});
      chk("dev", {6'h00, dv}, {5'h00, emb_int_ep_en, emb_addr, emb_enabled, hub_chg});
   endtask : st
   // one-cycle pulse on {sof_valid, dn_wake, emb_babble}
   task automatic pulse(input logic [2:0] m);
      @(posedge clk);
      {sof_valid, dn_wake, emb_babble} <= m;
      sof_frame <= 11'h5a3;
      @(posedge clk);
      {sof_valid, dn_wake, emb_babble} <= 3'h0;
   endtask : pulse
   ////////////////////////////////////////////////////////////
   // resume length counted in the background, as it overlaps link traffic;
   // the cycle ceiling sits well above the less than two thousand cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (up_resume) begin
         res_cyc <= res_cyc + 8'h01;
      end else if (res_cyc != 8'h00) begin
         res_len <= res_cyc;
         res_n <= res_n + 8'h01;
         res_cyc <= 8'h00;
      end
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      st(2'h0, 5'h00, 10'h000);
      req(3'h2, 8'h01);
      st(2'h0, 5'h00, 10'h001);
      req(3'h3, 8'h2a);
      req(3'h0, 8'h80);
      st(2'h1, 5'h00, 10'h155);
      req(3'h0, 8'h82);
      st(2'h0, 5'h10, 10'h007);
      req(3'h0, 8'h02);
      st(2'h0, 5'h00, 10'h005);
      req(3'h0, 8'h81);
      st(2'h2, 5'h00, 10'h151);
      req(3'h1, 8'h02);
      st(2'h1, 5'h04, 10'h157);
      req(3'h0, 8'h06);
      req(3'h0, 8'h81);
      req(3'h0, 8'h01);
      st(2'h1, 5'h04, 10'h157);
      req(3'h0, 8'h06);
      req(3'h0, 8'h00);
      st(2'h0, 5'h00, 10'h151);
      req(3'h0, 8'h80);
      req(3'h0, 8'h81);
      req(3'h2, 8'h03);
      req(3'h1, 8'h02);
      repeat (RES + 10) @(posedge clk);
      st(2'h1, 5'h04, 10'h157);
      chk("resume", {8'h01, 8'(RES)}, {res_n, res_len});
      req(3'h0, 8'h06);
      req(3'h1, 8'h02);
      repeat (RES + 10) @(posedge clk);
      st(2'h1, 5'h00, 10'h155);
      chk("resume", {8'h02, 8'(RES)}, {res_n, res_len});
      pulse(3'h2);
      repeat (RES + 10) @(posedge clk);
      chk("resume", {8'h03, 8'(RES)}, {res_n, res_len});
      pulse(3'h1);
      repeat (4) @(posedge clk);
      chk("babble", 16'h0000, {15'h0000, emb_enabled});
      req(3'h1, 8'h01);
      st(2'h0, 5'h02, 10'h153);
      for (int c = 3; c < 8; c++) req(3'h0, 8'(c));
      st(2'h0, 5'h00, 10'h151);
      pulse(3'h4);
      req(3'h1, 8'h04);
      rd(3'h4, rdv);
      chk("frame_lo", 16'h00a3, {8'h00, rdv});
      rd(3'h5, rdv);
      chk("frame_hi", 16'h0005, {8'h00, rdv});
      rd(3'h7, rdv);
      chk("unmapped", 16'h0000, {8'h00, rdv});
      give_verdict();
   end
endmodule : hep_tb
`default_nettype wire
